/* verilog/elc_led.v */
// Enhanced indicator control: mode-select and behaviour registers, page select, timing, three outputs
`timescale 1ns/100ps
`default_nettype none
`include "elc_map.vh"
module elc_led #(
    parameter TICK_CYC = `ELC_TICK_CYC,
    parameter PULSE_CYC = `ELC_PULSE_CYC,
    parameter PULSE_ON_CYC = `ELC_PULSE_ON_CYC
) (
    input wire mclk,
    input wire nrst,
    input wire soft_rst,
    input wire sticky_rst_en,
    input wire [4:0] reg_addr,
    input wire reg_wr,
    input wire [15:0] reg_wdata,
    output reg [15:0] reg_rdata,
    input wire link_up,
    input wire [1:0] link_speed,
    input wire full_duplex,
    input wire activity,
    input wire collision,
    input wire an_fault,
    input wire [2:0] simple_led,
    output reg [2:0] led_on
);
    reg [15:0] page_reg;
    reg [15:0] mode_reg;
    reg [15:0] behav_reg;
    reg [31:0] tick_cnt_reg;
    reg [3:0] tick_div_reg;
    reg [31:0] pwm_cnt_reg;
    wire ext_page = (page_reg == `ELC_PAGE_EXT);
    wire sticky_clr = soft_rst & ~sticky_rst_en;
    wire tick = (tick_cnt_reg == TICK_CYC - 1);
    wire [1:0] rate = behav_reg[`ELC_B_RATE_HI:`ELC_B_RATE_LO];
    wire enhanced = behav_reg[`ELC_B_METHOD];
    wire pwm_wrap = (pwm_cnt_reg == PULSE_CYC - 1);
    // Pulsing only gates; an output that is off stays off
    wire pwm_on = ~behav_reg[`ELC_B_PULSE] | (pwm_cnt_reg < PULSE_ON_CYC);

    // Speed subsets accepted by link functions; 00, 01, 10 are 10, 100, 1000
    function link_match;
        input [3:0] fn;
        input [1:0] spd;
        begin
            case (fn)
                4'h0: link_match = 1'b1;
                4'h1: link_match = (spd == 2'b10);
                4'h2: link_match = (spd == 2'b01);
                4'h3: link_match = (spd == 2'b00);
                4'h4: link_match = (spd == 2'b01) | (spd == 2'b10);
                4'h5: link_match = (spd == 2'b00) | (spd == 2'b10);
                4'h6: link_match = (spd == 2'b00) | (spd == 2'b01);
                default: link_match = 1'b0;
            endcase
        end
    endfunction

    // Half blink period in 25 ms ticks is 8, 4, 2, 1 for rate codes 0..3
    function blink_bit;
        input [1:0] r;
        input [3:0] div;
        begin
            case (r)
                2'b00: blink_bit = div[3];
                2'b01: blink_bit = div[2];
                2'b10: blink_bit = div[1];
                2'b11: blink_bit = div[0];
                default: blink_bit = div[3];
            endcase
        end
    endfunction

    // Stretch spans two blink half periods, counted in ticks
    function [4:0] stretch_ticks;
        input [1:0] r;
        begin
            stretch_ticks = 5'h02 << (2'h3 - r);
        end
    endfunction

    wire blink_phase = blink_bit(rate, tick_div_reg);
    wire [4:0] stretch_len = stretch_ticks(rate);

    // Page select is not sticky
    // Any value is kept; only 0x0001 opens the extended page
    always @(posedge mclk) begin
        if (!nrst || soft_rst) begin
            page_reg <= `ELC_PAGE_MAIN;
        end else if (reg_wr && reg_addr == `ELC_ADDR_PAGE) begin
            page_reg <= reg_wdata;
        end
    end

    // A write that meets a software reset is dropped, so the reset wins
    always @(posedge mclk) begin
        if (!nrst || sticky_clr) begin
            mode_reg <= `ELC_MODE_RST;
            behav_reg <= `ELC_BEHAV_RST;
        end else if (reg_wr && ext_page && !soft_rst) begin
            if (reg_addr == `ELC_ADDR_MODE_SEL) begin
                mode_reg <= reg_wdata & `ELC_MODE_WMASK;
            end
            if (reg_addr == `ELC_ADDR_BEHAV) begin
                behav_reg <= reg_wdata & `ELC_BEHAV_WMASK;
            end
        end
    end

    // Registered read port; unmapped addresses read as zero
    always @(posedge mclk) begin
        if (!nrst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_addr == `ELC_ADDR_PAGE) begin
            reg_rdata <= page_reg;
        end else if (ext_page && reg_addr == `ELC_ADDR_MODE_SEL) begin
            reg_rdata <= mode_reg;
        end else if (ext_page && reg_addr == `ELC_ADDR_BEHAV) begin
            reg_rdata <= behav_reg;
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // Free-running dividers of the core clock
    // Counters are 32 bits so any sensible tick or pulse period fits
    always @(posedge mclk) begin
        if (!nrst) begin
            tick_cnt_reg <= 32'h0;
            tick_div_reg <= 4'h0;
            pwm_cnt_reg <= 32'h0;
        end else begin
            tick_cnt_reg <= tick ? 32'h0 : tick_cnt_reg + 32'h1;
            if (tick) begin
                tick_div_reg <= tick_div_reg + 4'h1;
            end
            pwm_cnt_reg <= pwm_wrap ? 32'h0 : pwm_cnt_reg + 32'h1;
        end
    end

    genvar i;
    generate
        for (i = 0; i < 3; i = i + 1) begin : g_led
            // Output i takes its function from bits 4i+3 down to 4i
            wire [3:0] fn = mode_reg[4 * i + 3:4 * i];
            wire stretch_mode = behav_reg[`ELC_B_STRETCH0 + i];
            wire no_comb = behav_reg[`ELC_B_NOCOMB0 + i];
            wire use_col = (fn == `ELC_FN_DPX_COL) | (fn == `ELC_FN_COL);
            wire evt = use_col ? collision : activity;
            reg [4:0] hold_reg;
            reg base;
            reg out;
            // Tick-granular hold; one extra tick guarantees the least time
            // An event held high keeps reloading, so the output never times out
            always @(posedge mclk) begin
                if (!nrst) begin
                    hold_reg <= 5'h0;
                end else if (evt) begin
                    hold_reg <= stretch_len + 5'h1;
                end else if (tick && hold_reg != 5'h0) begin
                    hold_reg <= hold_reg - 5'h1;
                end
            end

            wire act_on = (hold_reg != 5'h0);
            wire act_disp = act_on & (stretch_mode | blink_phase);

            // Reserved codes 7, 11 and 13 leave the output dark
            always @* begin
                base = 1'b0;
                out = 1'b0;
                if (fn <= 4'h6) begin
                    base = link_up & link_match(fn, link_speed);
                    out = no_comb ? base : base & ~act_disp;
                end else begin
                    case (fn)
                        `ELC_FN_DPX_COL: begin
                            // Collision flips the duplex indication instead of blanking it
                            base = link_up & full_duplex;
                            out = no_comb ? base : base ^ act_disp;
                        end
                        `ELC_FN_COL: out = act_disp;
                        `ELC_FN_ACT: out = act_disp;
                        `ELC_FN_AN_FAULT: out = an_fault;
                        `ELC_FN_OFF: out = 1'b0;
                        `ELC_FN_ON: out = 1'b1;
                        default: out = 1'b0;
                    endcase
                end
            end

            // One more register: a cycle of latency, but no glitches on the pins
            always @(posedge mclk) begin
                if (!nrst) begin
                    led_on[i] <= 1'b0;
                end else if (enhanced) begin
                    led_on[i] <= out & pwm_on;
                end else begin
                    led_on[i] <= simple_led[i];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

/* shared/elc_map.vh */
// Register map, reset values and timing constants of the indicator control block
`ifndef ELC_MAP_VH
`define ELC_MAP_VH
`define ELC_ADDR_MODE_SEL 5'h10
`define ELC_ADDR_BEHAV 5'h11
`define ELC_ADDR_PAGE 5'h1f
`define ELC_PAGE_MAIN 16'h0000
`define ELC_PAGE_EXT 16'h0001
`define ELC_MODE_RST 16'h021a
`define ELC_MODE_WMASK 16'h0fff
`define ELC_BEHAV_RST 16'h04e0
`define ELC_BEHAV_WMASK 16'h1cf7
`define ELC_B_PULSE 12
`define ELC_B_RATE_HI 11
`define ELC_B_RATE_LO 10
`define ELC_B_STRETCH0 5
`define ELC_B_METHOD 4
`define ELC_B_NOCOMB0 0
`define ELC_FN_AN_FAULT 4'hc
`define ELC_FN_OFF 4'he
`define ELC_FN_ON 4'hf
`define ELC_FN_DPX_COL 4'h8
`define ELC_FN_COL 4'h9
`define ELC_FN_ACT 4'ha
`define ELC_CLK_HZ 125000000
`define ELC_TICK_US 25000
`define ELC_TICK_CYC ((`ELC_CLK_HZ / 1000000) * `ELC_TICK_US)
`define ELC_PULSE_HZ 5000
`define ELC_PULSE_PCT 20
`define ELC_PULSE_CYC (`ELC_CLK_HZ / `ELC_PULSE_HZ)
`define ELC_PULSE_ON_CYC ((`ELC_PULSE_CYC * `ELC_PULSE_PCT) / 100)
`endif

/* verif/elc_led_asserts.sv */
// Port-level assertions for the indicator control block
`timescale 1ns/100ps
`default_nettype none
module elc_led_asserts (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic soft_rst,
    input wire logic sticky_rst_en,
    input wire logic [4:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic [2:0] simple_led,
    input wire logic [2:0] led_on
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    logic pg;
    // Own page copy, so behaviour readback is judged only on the extended page
    always @(posedge mclk) begin
        if (!nrst || soft_rst)
            pg <= 1'b0;
        else if (reg_wr && reg_addr == 5'h1f)
            pg <= reg_wdata == 16'h0001;
    end
    property p_rst; $rose(nrst) |-> led_on == 3'h0 && reg_rdata == 16'h0; endproperty
    a_rst: assert property (p_rst) else $error("reset outputs");
    property p_boot; $rose(nrst) |=> led_on == $past(simple_led); endproperty
    a_boot: assert property (p_boot) else $error("simple method after reset");
    property p_unmap; reg_addr < 5'h10 |=> reg_rdata == 16'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    property p_hold;
        !reg_wr && !soft_rst ##1 !reg_wr && !soft_rst && $stable(reg_addr) |=> $stable(reg_rdata);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_page;
        reg_wr && reg_addr == 5'h1f && !soft_rst ##1 reg_addr == 5'h1f |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    a_page: assert property (p_page) else $error("page readback");
    property p_behav;
        pg && reg_wr && reg_addr == 5'h11 && !soft_rst ##1 reg_addr == 5'h11
            |=> reg_rdata == ($past(reg_wdata, 2) & 16'h1cf7);
    endproperty
    a_behav: assert property (p_behav) else $error("behaviour readback");
    property p_spage; soft_rst ##1 reg_addr == 5'h1f |=> reg_rdata == 16'h0; endproperty
    a_spage: assert property (p_spage) else $error("page after soft reset");
    property p_soft; soft_rst && !sticky_rst_en |=> ##1 led_on == $past(simple_led); endproperty
    a_soft: assert property (p_soft) else $error("defaults after soft reset");
endmodule
`default_nettype wire

/* verif/elc_led_lamps.sv */
// Lamp model: counts lit cycles on indicator outputs zero and two
`timescale 1ns/100ps
`default_nettype none
module elc_led_lamps (
    input wire logic mclk,
    input wire logic clr,
    input wire logic [2:0] led_on,
    output logic [7:0] lit0,
    output logic [7:0] lit2
);
    // Lamps are lit while the output is high
    always @(posedge mclk) begin
        lit0 <= clr ? 8'h00 : lit0 + {7'h00, led_on[0]};
        lit2 <= clr ? 8'h00 : lit2 + {7'h00, led_on[2]};
    end
endmodule
`default_nettype wire

/* verif/tb_top.sv */
// Self-checking bench for the indicator control block
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin \
    n_tests++; \
    if ((g) !== (e)) begin \
        mismatches++; \
        $display("MISMATCH t=%0t %h %h", $time, (g), (e)); \
    end \
end
module tb_top;
    logic mclk = 0, nrst = 0, soft_rst = 0, sticky_rst_en = 1, reg_wr = 0, link_up = 0, full_duplex = 0;
    logic activity = 0, collision = 0, an_fault = 0, clr = 0;
    logic [4:0] reg_addr = 5'h00;
    logic [15:0] reg_wdata = 16'h0;
    logic [1:0] link_speed = 2'h0;
    logic [2:0] simple_led = 3'h5;
    wire [15:0] reg_rdata;
    wire [2:0] led_on;
    wire [7:0] lit0, lit2;
    int mismatches = 0, n_tests = 0;
    always #4 mclk = ~mclk;
    elc_led #(.TICK_CYC(10), .PULSE_CYC(10), .PULSE_ON_CYC(2)) dut (
        .mclk(mclk),
        .nrst(nrst),
        .soft_rst(soft_rst),
        .sticky_rst_en(sticky_rst_en),
        .reg_addr(reg_addr),
        .reg_wr(reg_wr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .link_up(link_up),
        .link_speed(link_speed),
        .full_duplex(full_duplex),
        .activity(activity),
        .collision(collision),
        .an_fault(an_fault),
        .simple_led(simple_led),
        .led_on(led_on)
    );
    elc_led_lamps lamps (
        .mclk(mclk),
        .clr(clr),
        .led_on(led_on),
        .lit0(lit0),
        .lit2(lit2)
    );
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        cyc(1);
        reg_addr = a; reg_wdata = d; reg_wr = 1;
        cyc(1);
        reg_wr = 0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        cyc(1);
        reg_addr = a;
        cyc(2);
        `CHK(reg_rdata, e)
    endtask
    task automatic close_out;
        $display("tests=%0d mismatches=%0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        cyc(6);
        nrst = 1;
        rd(5'h00, 16'h0);
        `CHK(led_on, 3'h5)
        simple_led = 3'h2;
        rd(5'h11, 16'h0);
        wr(5'h1f, 16'h0001);
        rd(5'h10, 16'h021a);
        rd(5'h11, 16'h04e0);
        wr(5'h10, 16'h0fec);
        wr(5'h11, 16'h0c17);
        cyc(2);
        `CHK(led_on, 3'h4)
        an_fault = 1;
        cyc(2);
        `CHK(led_on, 3'h5)
        wr(5'h11, 16'h1c17);
        cyc(3);
        clr = 1;
        cyc(1);
        clr = 0;
        cyc(10);
        `CHK(lit2, 8'h02)
        an_fault = 0;
        link_up = 1;
        full_duplex = 1;
        collision = 1;
        wr(5'h10, 16'h0ee8);
        wr(5'h11, 16'h0c30);
        cyc(3);
        `CHK(led_on[0], 1'b0)
        wr(5'h11, 16'h0c31);
        cyc(3);
        `CHK(led_on[0], 1'b1)
        collision = 0;
        wr(5'h10, 16'h0eea);
        cyc(40);
        activity = 1;
        cyc(1);
        activity = 0;
        clr = 1;
        cyc(1);
        clr = 0;
        cyc(40);
        `CHK(lit0 >= 8'h13 && lit0 <= 8'h1f, 1'b1)
        reg_addr = 5'h1f;
        soft_rst = 1;
        cyc(1);
        soft_rst = 0;
        rd(5'h1f, 16'h0);
        wr(5'h1f, 16'h0001);
        rd(5'h11, 16'h0c31);
        sticky_rst_en = 0;
        soft_rst = 1;
        cyc(1);
        soft_rst = 0;
        cyc(2);
        `CHK(led_on, 3'h2)
        wr(5'h1f, 16'h0001);
        rd(5'h11, 16'h04e0);
        rd(5'h10, 16'h021a);
        link_speed = 2'b10;
        wr(5'h10, 16'h0120);
        wr(5'h11, 16'h0c17);
        cyc(2);
        `CHK(led_on, 3'h5)
        link_speed = 2'b01;
        cyc(2);
        `CHK(led_on, 3'h3)
        wr(5'h10, 16'h0eea);
        activity = 1;
        wr(5'h11, 16'h0c10);
        cyc(2);
        clr = 1;
        cyc(1);
        clr = 0;
        cyc(40);
        `CHK(lit0, 8'h14)
        activity = 0;
        close_out();
    end
endmodule
bind elc_led elc_led_asserts chk (
    .mclk(mclk),
    .nrst(nrst),
    .soft_rst(soft_rst),
    .sticky_rst_en(sticky_rst_en),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .simple_led(simple_led),
    .led_on(led_on)
);
`default_nettype wire
